// ### tse_cfg.svh
// Offsets, field positions, codes and reset values of the trap syndrome encoder.
// Assumes a 32-bit APB with one aligned word per register.
`ifndef TSE_CFG_SVH
`define TSE_CFG_SVH

`define TSE_OFF_WAIT_SYN   12'h000
`define TSE_OFF_COP_SYN    12'h004
`define TSE_OFF_CTRL       12'h008
`define TSE_OFF_STATUS     12'h00C

`define TSE_SYN_W          25
`define TSE_CV_BIT         24
`define TSE_PREDICATE_CODE_HI        23
`define TSE_PREDICATE_CODE_LO        20
`define TSE_COPROC_OP_SECOND_HI        19
`define TSE_COPROC_OP_SECOND_LO        17
`define TSE_COPROC_OP_FIRST_HI        16
`define TSE_COPROC_OP_FIRST_LO        14
`define TSE_PRI_HI         13
`define TSE_PRI_LO         10
`define TSE_REG_HI         9
`define TSE_REG_LO         5
`define TSE_SEC_HI         4
`define TSE_SEC_LO         1
`define TSE_RV_BIT         2
`define TSE_DIR_BIT        0

`define TSE_PREDICATE_CODE_ALWAYS    4'hE
`define TSE_PREDICATE_CODE_UNKNOWN   4'h0
`define TSE_TI_WFI         2'h0
`define TSE_TI_WFE         2'h1
`define TSE_TI_WFIT        2'h2
`define TSE_TI_WFET        2'h3
`define TSE_FP_OP_SECOND   3'h0
`define TSE_FP_OP_FIRST    3'h7
`define TSE_FP_SECONDARY   4'h0
`define TSE_GPR_PC32       4'hF
`define TSE_GPR_ZR64       5'h1F
`define TSE_DIR_WRITE      1'h0
`define TSE_DIR_READ       1'h1
`define TSE_EC_COPROC15    6'h03

`define TSE_CTRL_EL1_EVENT_WAIT_NO_TRAP_BIT  0
`define TSE_CTRL_EL1_IRQ_WAIT_NO_TRAP_BIT  1
`define TSE_CTRL_HTWE_BIT  2
`define TSE_CTRL_HTWI_BIT  3
`define TSE_CTRL_STWE_BIT  4
`define TSE_CTRL_STWI_BIT  5
`define TSE_CTRL_PASSAL_BIT 8
`define TSE_CTRL_W         9
`define TSE_CTRL_MASK      9'h13F
`define TSE_CTRL_RESET     9'h003

`endif

// ### tse_pkg.sv
// Types shared by the trap syndrome encoder and its surroundings.
// Assumes tse_cfg.svh for the numeric constants.
package tse_pkg;

  typedef enum logic [1:0] {
    TSE_EL0 = 2'h0,
    TSE_EL1 = 2'h1,
    TSE_EL2 = 2'h2,
    TSE_EL3 = 2'h3
  } tse_level_t;

  // Instruction context common to both trap kinds
  typedef struct packed {
    logic       from_64bit;
    logic       compact;
    logic       conditional;
    logic [3:0] predicate_code;
  } tse_ctx_t;

  typedef struct packed {
    tse_ctx_t   ctx;
    logic       is_event;
    logic       timed;
    logic [4:0] reg_num;
    tse_level_t cur_el;
  } tse_wait_req_t;

  typedef struct packed {
    tse_ctx_t   ctx;
    logic       fp_read;
    logic       is_write;
    logic [2:0] op_first;
    logic [2:0] op_second;
    logic [3:0] primary;
    logic [3:0] secondary;
    logic [3:0] fp_reg_sel;
    logic [3:0] gpr;
    logic       unpredictable;
  } tse_cop_req_t;

endpackage : tse_pkg

// ### tse_encoder.sv
// Trap syndrome encoder: decides wait-instruction traps, builds and holds the
// wait and coprocessor-transfer syndromes, and exposes them over APB.
// Assumes requests from the pipeline are synchronous one-cycle strobes on pclk.
`timescale 1ns/10ps
`include "tse_cfg.svh"

module tse_encoder
  import tse_pkg::*;
#(
  parameter bit TIMED_WAIT = 1'b1,
  parameter bit COMPACT_CV = 1'b1
) (
  input  wire logic          pclk,
  input  wire logic          presetn,
  input  wire logic          psel,
  input  wire logic          penable,
  input  wire logic          pwrite,
  input  wire logic [11:0]   paddr,
  input  wire logic [31:0]   pwdata,
  output logic      [31:0]   prdata,
  output logic               pready,
  output logic               pslverr,
  input  wire logic          wait_valid,
  input  wire tse_wait_req_t wait_req,
  output logic               wait_trapped,
  output tse_level_t         wait_trap_el,
  input  wire logic          cop_valid,
  input  wire tse_cop_req_t  cop_req,
  output logic               cop_captured,
  output logic      [5:0]    exception_class,
  output logic      [24:0]   wait_trap_syndrome,
  output logic      [24:0]   coproc_trap_syndrome
);

  // Registers
  logic [`TSE_CTRL_W-1:0] ctrl;
  logic [24:0]            wait_syn;
  logic [24:0]            cop_syn;
  logic                   last_coproc;
  tse_level_t             last_el;
  logic [15:0]            trap_count;
  logic [31:0]            rdata_q;
  logic                   err_q;

  // Control fields
  wire logic el1_event_wait_no_trap = ctrl[`TSE_CTRL_EL1_EVENT_WAIT_NO_TRAP_BIT];
  wire logic el1_irq_wait_no_trap   = ctrl[`TSE_CTRL_EL1_IRQ_WAIT_NO_TRAP_BIT];
  wire logic hyp_event_wait_trap    = ctrl[`TSE_CTRL_HTWE_BIT];
  wire logic hyp_irq_wait_trap      = ctrl[`TSE_CTRL_HTWI_BIT];
  wire logic sec_event_wait_trap    = ctrl[`TSE_CTRL_STWE_BIT];
  wire logic sec_irq_wait_trap      = ctrl[`TSE_CTRL_STWI_BIT];
  wire logic report_pass_as_always  = ctrl[`TSE_CTRL_PASSAL_BIT];

  // Condition fields, shared by both syndromes
  function automatic logic [4:0] predicate_code_fields(input tse_ctx_t c, input logic pass_al);
    logic [4:0] r;
    r = {1'b1, `TSE_PREDICATE_CODE_ALWAYS};
    if (c.from_64bit) begin
      r = {1'b1, `TSE_PREDICATE_CODE_ALWAYS};
    end else if (c.compact && !COMPACT_CV) begin
      r = {1'b0, `TSE_PREDICATE_CODE_UNKNOWN};
    end else if (!c.conditional) begin
      r = {1'b1, `TSE_PREDICATE_CODE_ALWAYS};
    end else if (pass_al) begin
      r = {1'b1, `TSE_PREDICATE_CODE_ALWAYS};
    end else begin
      r = {1'b1, c.predicate_code};
    end
    return r;
  endfunction : predicate_code_fields

  // Wait trap routing by the three levels' enables
  wire logic el1_wait_trap = wait_req.is_event ? !el1_event_wait_no_trap : !el1_irq_wait_no_trap;
  wire logic el2_wait_trap = wait_req.is_event ? hyp_event_wait_trap : hyp_irq_wait_trap;
  wire logic el3_wait_trap = wait_req.is_event ? sec_event_wait_trap : sec_irq_wait_trap;
  wire logic at_el0        = (wait_req.cur_el == TSE_EL0);
  wire logic below_el2     = (wait_req.cur_el == TSE_EL0) || (wait_req.cur_el == TSE_EL1);
  wire logic below_el3     = (wait_req.cur_el != TSE_EL3);

  wire logic take_el1 = at_el0 && el1_wait_trap;
  wire logic take_el2 = !take_el1 && below_el2 && el2_wait_trap;
  wire logic take_el3 = !take_el1 && !take_el2 && below_el3 && el3_wait_trap;
  wire logic wait_take = wait_valid && (take_el1 || take_el2 || take_el3);

  wire tse_level_t wait_target = take_el1 ? TSE_EL1 : (take_el2 ? TSE_EL2 : TSE_EL3);

  // Wait syndrome assembly
  wire logic       timed_ok   = TIMED_WAIT && wait_req.timed;
  wire logic [1:0] wait_kind  = {timed_ok, wait_req.is_event};
  wire logic [4:0] wait_predicate_code  = predicate_code_fields(wait_req.ctx, report_pass_as_always);
  wire logic [4:0] wait_rnum  = timed_ok ? wait_req.reg_num : 5'h00;
  wire logic       wait_rv    = timed_ok;

  wire logic [24:0] next_wait_syn = {
    wait_predicate_code,
    10'h000,
    wait_rnum,
    2'h0,
    wait_rv,
    wait_kind
  };

  // Coprocessor syndrome assembly
  wire logic [4:0] cop_predicate_code = predicate_code_fields(cop_req.ctx, report_pass_as_always);
  wire logic [2:0] cop_op2  = cop_req.fp_read ? `TSE_FP_OP_SECOND : cop_req.op_second;
  wire logic [2:0] cop_op1  = cop_req.fp_read ? `TSE_FP_OP_FIRST : cop_req.op_first;
  wire logic [3:0] cop_pri  = cop_req.fp_read ? cop_req.fp_reg_sel : cop_req.primary;
  wire logic [3:0] cop_sec  = cop_req.fp_read ? `TSE_FP_SECONDARY : cop_req.secondary;
  wire logic       gpr_pc   = (cop_req.gpr == `TSE_GPR_PC32);
  // Register 15 reports the zero-register code whether or not well defined
  wire logic [4:0] cop_gpr  = gpr_pc ? `TSE_GPR_ZR64 : {1'b0, cop_req.gpr};
  wire logic       cop_dir  = (cop_req.is_write && !cop_req.fp_read) ? `TSE_DIR_WRITE
                                                                      : `TSE_DIR_READ;

  wire logic [24:0] next_cop_syn = {
    cop_predicate_code,
    cop_op2,
    cop_op1,
    cop_pri,
    cop_gpr,
    cop_sec,
    cop_dir
  };

  // APB decode
  wire logic setup_phase = psel && !penable;
  wire logic access_wr   = psel && penable && pwrite;
  wire logic hit_wait    = (paddr == `TSE_OFF_WAIT_SYN);
  wire logic hit_cop     = (paddr == `TSE_OFF_COP_SYN);
  wire logic hit_ctrl    = (paddr == `TSE_OFF_CTRL);
  wire logic hit_status  = (paddr == `TSE_OFF_STATUS);
  wire logic hit_any     = hit_wait || hit_cop || hit_ctrl || hit_status;
  wire logic bad_access  = !hit_any || (hit_status && pwrite);
  wire logic sw_wait_wr  = access_wr && hit_wait;
  wire logic sw_cop_wr   = access_wr && hit_cop;
  wire logic sw_ctrl_wr  = access_wr && hit_ctrl;

  wire logic [31:0] status_word = {
    trap_count,
    6'h00,
    exception_class,
    last_el,
    1'b0,
    last_coproc
  };

  wire logic [31:0] next_rdata = hit_wait   ? {7'h00, wait_syn} :
                                 hit_cop    ? {7'h00, cop_syn} :
                                 hit_status ? status_word :
                                 hit_ctrl   ? {23'h000000, ctrl} :
                                              32'h00000000;

  assign pready               = 1'b1;
  assign prdata               = rdata_q;
  assign pslverr              = err_q && psel && penable;
  assign wait_trap_syndrome   = wait_syn;
  assign coproc_trap_syndrome = cop_syn;

  // Read data and error are registered in the setup phase
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rdata_q <= 32'h00000000;
      err_q   <= 1'b0;
    end else if (setup_phase) begin
      rdata_q <= pwrite ? 32'h00000000 : next_rdata;
      err_q   <= bad_access;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl <= `TSE_CTRL_RESET;
    end else if (sw_ctrl_wr) begin
      ctrl <= pwdata[`TSE_CTRL_W-1:0] & `TSE_CTRL_MASK;
    end
  end

  // Whole syndrome replaced in the commit cycle; a trap beats a software write.
  // Reset value is a convenience only, software treats it as unknown.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wait_syn <= 25'h0000000;
    end else if (wait_take) begin
      wait_syn <= next_wait_syn;
    end else if (sw_wait_wr) begin
      wait_syn <= pwdata[24:0];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cop_syn <= 25'h0000000;
    end else if (cop_valid) begin
      cop_syn <= next_cop_syn;
    end else if (sw_cop_wr) begin
      cop_syn <= pwdata[24:0];
    end
  end

  // Trap outcome toward the pipeline; wait_trapped and cop_captured are one-cycle pulses
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wait_trapped <= 1'b0;
      wait_trap_el <= TSE_EL0;
      cop_captured <= 1'b0;
    end else begin
      wait_trapped <= wait_take;
      wait_trap_el <= wait_take ? wait_target : wait_trap_el;
      cop_captured <= cop_valid;
    end
  end

  // Status of the latest trap; a coprocessor trap takes precedence
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      last_coproc     <= 1'b0;
      last_el         <= TSE_EL0;
      exception_class <= 6'h00;
    end else if (cop_valid) begin
      // A wait trap in the same cycle still records its level
      last_coproc     <= 1'b1;
      last_el         <= wait_take ? wait_target : last_el;
      exception_class <= `TSE_EC_COPROC15;
    end else if (wait_take) begin
      last_coproc     <= 1'b0;
      last_el         <= wait_target;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      trap_count <= 16'h0000;
    end else if (wait_take || cop_valid) begin
      trap_count <= trap_count + 16'h0001;
    end
  end

endmodule : tse_encoder

// ### tse_encoder_asserts.sv
// Concurrent checks on the ports of the trap syndrome encoder.
// Assumes one pclk domain and an active-low asynchronous presetn.
`timescale 1ns/10ps
module tse_encoder_asserts
  import tse_pkg::*;
(
  input wire logic          pclk,
  input wire logic          presetn,
  input wire logic          psel,
  input wire logic          penable,
  input wire logic          pready,
  input wire logic          wait_valid,
  input wire tse_wait_req_t wait_req,
  input wire logic          wait_trapped,
  input wire logic [24:0]   wait_trap_syndrome,
  input wire logic          cop_valid,
  input wire tse_cop_req_t  cop_req,
  input wire logic          cop_captured,
  input wire logic [5:0]    exception_class,
  input wire logic [24:0]   coproc_trap_syndrome
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  apb_ready_a: assert property (psel && penable |-> pready)
    else $error("pready low in access phase");
  cop_pulse_a: assert property (cop_valid |=> cop_captured && exception_class == 6'h03)
    else $error("coprocessor capture missing");
  cop_dir_a: assert property (cop_valid |=> coproc_trap_syndrome[0] == !$past(cop_req.is_write && !cop_req.fp_read))
    else $error("direction bit wrong");
  cop_fp_a: assert property (cop_valid && cop_req.fp_read |=> coproc_trap_syndrome[19:14] == 6'h07
    && coproc_trap_syndrome[4:1] == 4'h0) else $error("fp read fields wrong");
  cop_gpr_a: assert property (cop_valid && cop_req.gpr == 4'hF |=> coproc_trap_syndrome[9:5] == 5'h1F)
    else $error("register 15 not reported as 1F");
  cop_state_a: assert property (cop_valid && cop_req.ctx.from_64bit |=> coproc_trap_syndrome[24:20] == 5'h1E)
    else $error("64-bit state condition wrong");
  wait_src_a: assert property (wait_trapped |-> $past(wait_valid) && $past(wait_req.cur_el) != TSE_EL3)
    else $error("wait trap without cause");
  wait_kind_a: assert property (wait_trapped |-> wait_trap_syndrome[1:0] == $past({wait_req.timed, wait_req.is_event}))
    else $error("wait kind wrong");
  wait_res_a: assert property (wait_trapped |-> wait_trap_syndrome[19:10] == 10'h0 && wait_trap_syndrome[4:3] == 2'h0
    && wait_trap_syndrome[2] == wait_trap_syndrome[1]) else $error("wait reserved or valid bit wrong");
  wait_state_a: assert property (wait_valid && wait_req.ctx.from_64bit ##1 wait_trapped |-> wait_trap_syndrome[24:20] == 5'h1E)
    else $error("wait 64-bit condition wrong");
endmodule : tse_encoder_asserts

bind tse_encoder tse_encoder_asserts i_tse_encoder_asserts (.*);

// ### tse_pipe_model.sv
// Pipeline model issuing one-cycle wait and coprocessor trap strobes.
// Assumes tasks are entered right after a rising pclk edge.
`timescale 1ns/10ps
module tse_pipe_model
  import tse_pkg::*;
(
  input  wire logic    pclk,
  output logic         wait_valid,
  output tse_wait_req_t wait_req,
  output logic         cop_valid,
  output tse_cop_req_t  cop_req
);
  initial begin
    wait_valid = 1'b0;
    cop_valid  = 1'b0;
    wait_req   = '0;
    cop_req    = '0;
  end
  // Idle request buses show the inverse so stale values are never trusted
  task automatic send_wait(input tse_wait_req_t r, input int gap);
    repeat (gap + 1) @(posedge pclk);
    wait_valid <= 1'b1;
    wait_req   <= r;
    @(posedge pclk);
    wait_valid <= 1'b0;
    wait_req   <= ~r;
  endtask : send_wait
  task automatic send_cop(input tse_cop_req_t r, input int gap);
    repeat (gap + 1) @(posedge pclk);
    cop_valid <= 1'b1;
    cop_req   <= r;
    @(posedge pclk);
    cop_valid <= 1'b0;
    cop_req   <= ~r;
  endtask : send_cop
endmodule : tse_pipe_model

// ### tse_encoder_tb_top.sv
// Self-checking bench: APB master, pipeline model and queued expectations.
// Assumes default parameters TIMED_WAIT=1 and COMPACT_CV=1.
`timescale 1ns/10ps
module tse_encoder_tb_top;
  import tse_pkg::*;
  logic          pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [11:0]   paddr = 12'h000;
  logic [31:0]   pwdata = 32'h0, prdata;
  logic          pready, pslverr, wait_valid, wait_trapped, cop_valid, cop_captured;
  tse_wait_req_t wait_req, wr;
  tse_cop_req_t  cop_req, cr;
  tse_level_t    wait_trap_el;
  logic [5:0]    en;
  logic [24:0]   wait_trap_syndrome, coproc_trap_syndrome;
  logic [32:0]   wq[$], cq[$], rq[$];
  int            seed = 33160, compares = 0, miscompares = 0, cycles = 0;

  always #25 pclk = ~pclk;

  tse_encoder i_tse_encoder (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .wait_valid(wait_valid), .wait_req(wait_req), .wait_trapped(wait_trapped),
    .wait_trap_el(wait_trap_el), .cop_valid(cop_valid), .cop_req(cop_req), .cop_captured(cop_captured),
    .exception_class(), .wait_trap_syndrome(wait_trap_syndrome), .coproc_trap_syndrome(coproc_trap_syndrome));
  tse_pipe_model i_tse_pipe_model (.pclk(pclk), .wait_valid(wait_valid), .wait_req(wait_req),
    .cop_valid(cop_valid), .cop_req(cop_req));

  task automatic check(input string what, input logic [32:0] seen, input logic [32:0] exp);
    compares++;
    if (seen !== exp) begin
      miscompares++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  task automatic conclude;
    $display("compares %0d miscompares %0d", compares, miscompares);
    if (miscompares == 0 && compares > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : conclude

  function automatic logic [4:0] cc(input tse_ctx_t c, input logic p);
    return (c.from_64bit || !c.conditional || p) ? 5'h1E : {1'b1, c.predicate_code};
  endfunction : cc

  function automatic logic [32:0] wexp(input tse_wait_req_t w, input logic p, input logic [1:0] l);
    return {6'h00, l, cc(w.ctx, p), 10'h000, w.timed ? w.reg_num : 5'h00, 2'h0, w.timed, w.timed, w.is_event};
  endfunction : wexp

  // Level a wait traps to under the enable bits e, 0 when it does not trap
  function automatic logic [1:0] tgt(input tse_wait_req_t w, input logic [5:0] e);
    int k;
    k = w.is_event ? 0 : 1;
    if (w.cur_el == TSE_EL0 && !e[k]) return 2'h1;
    if (w.cur_el != TSE_EL2 && w.cur_el != TSE_EL3 && e[2 + k]) return 2'h2;
    if (w.cur_el != TSE_EL3 && e[4 + k]) return 2'h3;
    return 2'h0;
  endfunction : tgt

  function automatic logic [32:0] cexp(input tse_cop_req_t c, input logic p);
    return {8'h00, cc(c.ctx, p), c.fp_read ? 3'h0 : c.op_second, c.fp_read ? 3'h7 : c.op_first,
      c.fp_read ? c.fp_reg_sel : c.primary, (c.gpr == 4'hF) ? 5'h1F : {1'b0, c.gpr},
      c.fp_read ? 4'h0 : c.secondary, !(c.is_write && !c.fp_read)};
  endfunction : cexp

  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d, input logic [32:0] exp);
    psel    <= 1'b1;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    penable <= 1'b0;
    @(posedge pclk);
    penable <= 1'b1;
    if (!w) rq.push_back(exp);
    do @(posedge pclk); while (pready !== 1'b1);
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask : apb

  always @(posedge pclk) begin
    cycles++;
    if (cycles == 5000) begin
      miscompares++;
      conclude();
    end
    if (presetn && wait_trapped !== 1'b0)
      check("wait syndrome", {6'h00, wait_trap_el, wait_trap_syndrome}, wq.size() ? wq.pop_front() : 'x);
    if (presetn && cop_captured !== 1'b0)
      check("coproc syndrome", {8'h00, coproc_trap_syndrome}, cq.size() ? cq.pop_front() : 'x);
    if (psel && penable && pready && !pwrite)
      check("apb read", {pslverr, prdata}, rq.size() ? rq.pop_front() : 'x);
  end

  initial begin
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    apb(1'b0, 12'h008, 32'h0, {1'b0, 32'h0000_0003});
    apb(1'b0, 12'h010, 32'h0, {1'b1, 32'h0000_0000});
    apb(1'b1, 12'h000, 32'hFFFF_FFFF, 33'h0);
    apb(1'b0, 12'h000, 32'h0, {1'b0, 32'h01FF_FFFF});
    for (int p = 0; p < 2; p++) begin
      for (int i = 0; i < 40; i++) begin
        en = $random(seed);
        apb(1'b1, 12'h008, {23'h0, p[0], 2'h3, en}, 33'h0);
        apb(1'b0, 12'h008, 32'h0, {1'b0, 23'h0, p[0], 2'h0, en});
        wr = $random(seed);
        cr = $random(seed);
        if (i == 0) cr.gpr = 4'hF;
        if (tgt(wr, en) != 2'h0) wq.push_back(wexp(wr, p[0], tgt(wr, en)));
        cq.push_back(cexp(cr, p[0]));
        fork
          i_tse_pipe_model.send_wait(wr, $random(seed) & 3);
          i_tse_pipe_model.send_cop(cr, $random(seed) & 3);
        join
      end
      apb(1'b0, 12'h004, 32'h0, {1'b0, 32'(cexp(cr, p[0]))});
    end
    repeat (3) @(posedge pclk);
    check("pending", 33'(wq.size() + cq.size() + rq.size()), 33'h0);
    conclude();
  end
endmodule : tse_encoder_tb_top
